// File: tmc_pkg.sv
// tmc_pkg: constants for the transmitter mode controller
// assumes a single 40 MHz system clock and axi4-lite register access
// What this block does
// - operate enables supply stage and both indicators
// - standby disables supply stage, indicators off
// - operate requested by remote, panel, serial
// - standby entered from remote, panel, serial
// - over-temperature blocks entry to operate
// - missing amplifier blocks entry to operate
// - uncleared fault or remote standby blocks operate
// - open rf interlock forces mute
// - remote state output low while operating
// - fault-free output low while no fault
// - mute keeps operate state and indicator
// - fault lights indicator, forces standby
package tmc_pkg;
  // register byte offsets
  localparam logic [7:0] TMC_CTRL_OFS   = 8'h00; // bit0 operate, bit1 standby, bit2 fault clear
  localparam logic [7:0] TMC_STATUS_OFS = 8'h04; // live state
  localparam logic [7:0] TMC_IRQ_OFS    = 8'h08; // sticky events, clear on read
  localparam logic [7:0] TMC_MASK_OFS   = 8'h0c; // interrupt mask
  // control bits
  localparam int CTRL_OPR_BIT = 0;
  localparam int CTRL_STB_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  // status bits
  localparam int ST_OPERATE  = 0;
  localparam int ST_MUTE     = 1;
  localparam int ST_FAULT    = 2;
  localparam int ST_OVERTEMP = 3;
  localparam int ST_ABSENT   = 4;
  localparam int ST_RSTB     = 5;
  // event bits
  localparam int EV_OPERATE  = 0;
  localparam int EV_STANDBY  = 1;
  localparam int EV_FAULT    = 2;
  localparam int EV_MUTE     = 3;
  localparam int EV_REFUSED  = 4;
  localparam int EV_W        = 5;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
  // debounce time for remote inputs
  localparam int CLK_MHZ       = 40;
  localparam int DEBOUNCE_US   = 10;
  localparam int DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
  localparam int DEB_W         = 9;
  typedef enum logic [1:0] {AXI_RESP_OKAY = 2'b00, AXI_RESP_SLVERR = 2'b10} tmc_resp_type;
  typedef enum {TMC_STANDBY, TMC_OPERATE} tmc_mode_type;
endpackage : tmc_pkg

// File: tmc_sync_deb.sv
// tmc_sync_deb: three-flop synchroniser with a debounce filter
// assumes an asynchronous pin level on din
`timescale 1ns/1ps
module tmc_sync_deb
  import tmc_pkg::*;
(
  input  wire logic aclk,     // system clock
  input  wire logic aresetn,  // sync reset, active low
  input  wire logic din,      // raw pin level
  input  wire logic init,     // level held after reset
  output logic      dout      // clean level
);
  logic [2:0]       sync_r;
  logic [DEB_W-1:0] cnt_r;

  // three stages; only stages 2 and 3 are compared
  always_ff @(posedge aclk) begin
    if (!aresetn) sync_r <= {3{init}};
    else sync_r <= {sync_r[1:0], din};
  end

  // accept a new level only after it stays stable for the debounce time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      dout  <= init; // no false edge while the stages refill
    end else if (sync_r[1] != sync_r[2] || sync_r[2] == dout) begin
      cnt_r <= '0;
    end else if (cnt_r == DEB_W'(DEBOUNCE_CYC - 1)) begin
      cnt_r <= '0;
      dout  <= sync_r[2];
    end else begin
      cnt_r <= cnt_r + DEB_W'(1);
    end
  end
endmodule : tmc_sync_deb

// File: tmc_axil.sv
// tmc_axil: axi4-lite slave front end, one write and one read at a time
// assumes the core answers read data combinationally from rd_addr
`timescale 1ns/1ps
module tmc_axil
  import tmc_pkg::*;
(
  input  wire logic        aclk,     // system clock
  input  wire logic        aresetn,  // sync reset, active low
  input  wire logic [7:0]  awaddr,   // write address
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic [3:0]  wstrb,    // byte enables
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  output logic [1:0]       bresp,    // write response
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  input  wire logic [7:0]  araddr,   // read address
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  output logic [31:0]      rdata,    // read data
  output logic [1:0]       rresp,    // read response
  output logic             rvalid,   // read valid
  input  wire logic        rready,   // read ready
  output logic             wr_en,    // one-cycle write strobe
  output logic [7:0]       wr_addr,  // write address to core
  output logic [31:0]      wr_data,  // write data to core
  output logic             rd_en,    // one-cycle read strobe
  output logic [7:0]       rd_addr,  // read address to core
  input  wire logic [31:0] rd_data,  // read data from core
  input  wire logic        rd_hit    // read address is mapped
);
  logic aw_full_r, w_full_r;
  logic wr_fire;
  assign rd_en   = arvalid && arready;
  assign rd_addr = araddr;
  assign wr_fire = aw_full_r && w_full_r && !bvalid;

  // collect address and data in either order
  // readies are flops so every bus output leaves from a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      wready  <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awready   <= 1'b0;
        wr_addr   <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wready   <= 1'b0;
        // full-word registers; partial strobes write zero to the lanes whose strobe is low
        wr_data  <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
    end
  end

  // write strobe and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_en  <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= 2'b00;
    end else begin
      wr_en <= wr_fire;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (wr_addr == TMC_CTRL_OFS || wr_addr == TMC_MASK_OFS) ?
                  AXI_RESP_OKAY : AXI_RESP_SLVERR;
      end else if (bready) bvalid <= 1'b0;
    end
  end

  // read response, registered from the core's combinational mux
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'b00;
    end else if (rd_en) begin
      rvalid  <= 1'b1;
      arready <= 1'b0;
      rdata   <= rd_data;
      rresp   <= rd_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : tmc_axil

// File: tmc_top.sv
// tmc_top: operate/standby mode controller for the transmitter
// assumes remote pins are asynchronous and active low, panel keys and serial
// commands are one-cycle pulses on aclk, fault inputs are synchronous levels
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tmc_top
  import tmc_pkg::*;
(
  input  wire logic        aclk,                  // 40 MHz system clock
  input  wire logic        aresetn,               // sync reset, active low
  input  wire logic        remote_operate_n,      // remote operate request, low active
  input  wire logic        remote_standby_n,      // remote standby request, low active
  input  wire logic        panel_operate_key,     // panel operate pulse
  input  wire logic        panel_standby_key,     // panel standby pulse
  input  wire logic        serial_operate_cmd,    // serial operate pulse
  input  wire logic        serial_standby_cmd,    // serial standby pulse
  input  wire logic        amp_overtemp,          // heatsink above limit
  input  wire logic        amp_absent,            // presence interlock high
  input  wire logic        fault_detect,          // any other fault, level
  input  wire logic        rf_output_path_permit_in, // high when loop open
  input  wire logic        supply_ok,             // dc outputs healthy
  output logic             supply_stage_en,       // main supply stage enable
  output logic             operate_indicator,     // panel operate lamp
  output logic             amp_enable_indicator,  // amplifier enable lamp
  output logic             fault_indicator,       // panel fault lamp
  output logic             supply_good_indicator, // panel supply lamp
  output logic             mute,                  // rf mute
  output logic             remote_state_out,      // open collector: 0 drives low
  output logic             remote_state_oe_n,     // enable, low while driving
  output logic             remote_fault_free_out, // open collector: 0 drives low
  output logic             remote_fault_free_oe_n,// enable, low while driving
  output logic             irq,                   // level interrupt
  input  wire logic [7:0]  awaddr,                // axi write address
  input  wire logic        awvalid,               // axi
  output logic             awready,               // axi
  input  wire logic [31:0] wdata,                 // axi
  input  wire logic [3:0]  wstrb,                 // axi
  input  wire logic        wvalid,                // axi
  output logic             wready,                // axi
  output logic [1:0]       bresp,                 // axi
  output logic             bvalid,                // axi
  input  wire logic        bready,                // axi
  input  wire logic [7:0]  araddr,                // axi
  input  wire logic        arvalid,               // axi
  output logic             arready,               // axi
  output logic [31:0]      rdata,                 // axi
  output logic [1:0]       rresp,                 // axi
  output logic             rvalid,                // axi
  input  wire logic        rready                 // axi
);
  tmc_mode_type      mode_r;
  logic              rmt_opr_n, rmt_stb_n, rf_open;
  logic              wr_en, rd_en, rd_hit;
  logic [7:0]        wr_addr, rd_addr;
  logic [31:0]       wr_data, rd_data;
  logic              fault_latch_r;
  logic [EV_W-1:0]   ev_r, mask_r, ev_set;
  logic              sw_opr, sw_stb, sw_clr;
  logic              opr_req, stb_req, blocked, fault_now, rf_open_d_r;

  // remote pins are asynchronous and may bounce
  tmc_sync_deb u_opr (.aclk(aclk), .aresetn(aresetn), .din(remote_operate_n),
                      .init(1'b1), .dout(rmt_opr_n));
  tmc_sync_deb u_stb (.aclk(aclk), .aresetn(aresetn), .din(remote_standby_n),
                      .init(1'b1), .dout(rmt_stb_n));
  tmc_sync_deb u_rf  (.aclk(aclk), .aresetn(aresetn), .din(rf_output_path_permit_in),
                      .init(1'b1), .dout(rf_open));

  tmc_axil u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit)
  );

  // control register bits are write-one pulses, nothing stored
  assign sw_opr = wr_en && wr_addr == TMC_CTRL_OFS && wr_data[CTRL_OPR_BIT];
  assign sw_stb = wr_en && wr_addr == TMC_CTRL_OFS && wr_data[CTRL_STB_BIT];
  assign sw_clr = wr_en && wr_addr == TMC_CTRL_OFS && wr_data[CTRL_CLR_BIT];

  // request gathering from the four sources
  assign opr_req = !rmt_opr_n || panel_operate_key || serial_operate_cmd || sw_opr;
  assign stb_req = !rmt_stb_n || panel_standby_key || serial_standby_cmd || sw_stb;
  assign fault_now = amp_overtemp || amp_absent || fault_detect;
  // remote standby held low blocks operate, not just the edge
  assign blocked = amp_overtemp || amp_absent || fault_latch_r || fault_now
                   || !rmt_stb_n;

  // fault stays latched until software clears it with the cause gone
  always_ff @(posedge aclk) begin
    if (!aresetn) fault_latch_r <= 1'b0;
    else if (fault_now) fault_latch_r <= 1'b1;
    else if (sw_clr) fault_latch_r <= 1'b0;
  end

  // mode machine; standby has priority over operate
  always_ff @(posedge aclk) begin
    if (!aresetn) mode_r <= TMC_STANDBY;
    else begin
      case (mode_r)
        TMC_STANDBY: if (opr_req && !stb_req && !blocked) mode_r <= TMC_OPERATE;
        TMC_OPERATE: if (stb_req || fault_now) mode_r <= TMC_STANDBY;
        default:     mode_r <= TMC_STANDBY;
      endcase
    end
  end

  // outputs from flops, follow the mode one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_stage_en        <= 1'b0;
      operate_indicator      <= 1'b0;
      amp_enable_indicator   <= 1'b0;
      fault_indicator        <= 1'b0;
      supply_good_indicator  <= 1'b0;
      mute                   <= 1'b1;
      remote_state_out       <= 1'b1;
      remote_state_oe_n      <= 1'b1;
      remote_fault_free_out  <= 1'b1;
      remote_fault_free_oe_n <= 1'b1;
    end else begin
      // mute leaves mode and lamps alone
      supply_stage_en        <= mode_r == TMC_OPERATE;
      operate_indicator      <= mode_r == TMC_OPERATE;
      amp_enable_indicator   <= mode_r == TMC_OPERATE;
      supply_good_indicator  <= supply_ok;
      fault_indicator        <= fault_now || fault_latch_r;
      mute                   <= rf_open || mode_r != TMC_OPERATE;
      remote_state_out       <= 1'b0;
      remote_state_oe_n      <= mode_r != TMC_OPERATE;
      remote_fault_free_out  <= 1'b0;
      remote_fault_free_oe_n <= fault_now || fault_latch_r;
    end
  end

  // events; set wins over clear-on-read
  // filter leaves reset showing open; match it so reset raises no event
  always_ff @(posedge aclk) rf_open_d_r <= aresetn ? rf_open : 1'b1;
  always_comb begin
    ev_set = '0;
    ev_set[EV_OPERATE] = mode_r == TMC_STANDBY && opr_req && !stb_req && !blocked;
    ev_set[EV_STANDBY] = mode_r == TMC_OPERATE && (stb_req || fault_now);
    ev_set[EV_FAULT]   = fault_now && !fault_latch_r;
    ev_set[EV_MUTE]    = rf_open && !rf_open_d_r;
    ev_set[EV_REFUSED] = mode_r == TMC_STANDBY && opr_req && blocked;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ev_r <= '0;
    else if (rd_en && rd_addr == TMC_IRQ_OFS) ev_r <= ev_set;
    else ev_r <= ev_r | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) mask_r <= MASK_RESET;
    else if (wr_en && wr_addr == TMC_MASK_OFS) mask_r <= wr_data[EV_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(ev_r & mask_r);
  end

  // read mux; unmapped reads give zero and slverr
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (rd_addr)
      TMC_CTRL_OFS:   rd_data = 32'h0000_0000;
      TMC_STATUS_OFS: rd_data = {26'h0, !rmt_stb_n, amp_absent, amp_overtemp,
                                 fault_latch_r, mute, mode_r == TMC_OPERATE};
      TMC_IRQ_OFS:    rd_data = {27'h0, ev_r};
      TMC_MASK_OFS:   rd_data = {27'h0, mask_r};
      default:        rd_hit  = 1'b0;
    endcase
  end
endmodule : tmc_top

// File: tmc_props.sv
// tmc_props: concurrent checks on the mode controller ports
// assumes tmc_top timing: outputs follow a request two samples later
`timescale 1ns/1ps
module tmc_props (
  input wire logic aclk,                     // clock
  input wire logic aresetn,                  // sync reset, active low
  input wire logic panel_operate_key,        // panel operate
  input wire logic panel_standby_key,        // panel standby
  input wire logic serial_standby_cmd,       // serial standby
  input wire logic amp_overtemp,             // overtemp level
  input wire logic amp_absent,               // absent level
  input wire logic fault_detect,             // fault level
  input wire logic rf_output_path_permit_in, // high when open
  input wire logic supply_ok,                // supply level
  input wire logic supply_stage_en,          // supply enable
  input wire logic operate_indicator,        // operate lamp
  input wire logic amp_enable_indicator,     // amp lamp
  input wire logic fault_indicator,          // fault lamp
  input wire logic supply_good_indicator,    // supply lamp
  input wire logic mute,                     // rf mute
  input wire logic remote_state_oe_n,        // state enable
  input wire logic remote_fault_free_oe_n    // fault-free enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] open_cnt_r; // cycles the rf loop has stayed open
  // saturating count; the filter delays the open by up to 403 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || !rf_output_path_permit_in) open_cnt_r <= 10'h000;
    else if (open_cnt_r != 10'h3ff) open_cnt_r <= open_cnt_r + 10'h001;
  end
  property p_opr; supply_stage_en |-> operate_indicator && amp_enable_indicator
    && !remote_state_oe_n; endproperty
  a_opr: assert property (p_opr) else $error("operate outputs wrong");
  property p_stb; !supply_stage_en |-> !operate_indicator && !amp_enable_indicator
    && remote_state_oe_n && mute; endproperty
  a_stb: assert property (p_stb) else $error("standby outputs wrong");
  property p_good; $past(aresetn) |-> supply_good_indicator == $past(supply_ok); endproperty
  a_good: assert property (p_good) else $error("supply lamp wrong");
  property p_hot; amp_overtemp && $past(amp_overtemp) && !supply_stage_en |=> !supply_stage_en;
  endproperty
  a_hot: assert property (p_hot) else $error("operate while hot");
  property p_block; (amp_absent || fault_detect) && $past(amp_absent || fault_detect)
    && !supply_stage_en |=> !supply_stage_en; endproperty
  a_block: assert property (p_block) else $error("operate while blocked");
  property p_flt; fault_detect |-> ##[1:2] (fault_indicator && !supply_stage_en); endproperty
  a_flt: assert property (p_flt) else $error("fault not handled");
  property p_ffree; fault_detect |-> ##[1:2] remote_fault_free_oe_n; endproperty
  a_ffree: assert property (p_ffree) else $error("fault-free still driven");
  property p_rf; open_cnt_r >= 10'd420 |-> mute; endproperty
  a_rf: assert property (p_rf) else $error("open loop not muted");
  property p_mute; supply_stage_en && mute |-> operate_indicator; endproperty
  a_mute: assert property (p_mute) else $error("mute dropped lamp");
  property p_pri; panel_standby_key || serial_standby_cmd |-> ##2 !supply_stage_en; endproperty
  a_pri: assert property (p_pri) else $error("standby ignored");
  c_opr: cover property ($rose(supply_stage_en));
  c_flt: cover property ($rose(fault_indicator));
  c_mute: cover property (mute && supply_stage_en);
endmodule : tmc_props
bind tmc_top tmc_props u_props (.aclk, .aresetn, .panel_operate_key, .panel_standby_key,
  .serial_standby_cmd, .amp_overtemp, .amp_absent, .fault_detect, .rf_output_path_permit_in,
  .supply_ok, .supply_stage_en, .operate_indicator, .amp_enable_indicator, .fault_indicator,
  .supply_good_indicator, .mute, .remote_state_oe_n, .remote_fault_free_oe_n);

// File: tmc_far_model.sv
// tmc_far_model: remote terminal and rf loop seen from outside
// assumes pull-ups: a released pin reads high
`timescale 1ns/1ps
module tmc_far_model (
  input  wire logic aclk,              // clock
  input  wire logic op_req,            // ask for operate
  input  wire logic stb_req,           // ask for standby
  input  wire logic loop_open,         // break the rf loop
  output logic      remote_operate_n,  // pulled to ground to ask
  output logic      remote_standby_n,  // pulled to ground to ask
  output logic      rf_permit_open     // high while loop open
);
  // contacts close to ground only on request, else pull-up wins
  always_ff @(posedge aclk) begin
    remote_operate_n <= !op_req;
    remote_standby_n <= !stb_req;
    rf_permit_open   <= loop_open;
  end
endmodule : tmc_far_model

// File: tb_top.sv
// tb_top: directed bench for the transmitter mode controller
// assumes tmc_top, tmc_far_model and the bound checker
`timescale 1ns/1ps
module tb_top;
  import tmc_pkg::*;
  logic aclk, aresetn, pok, psk, sok, ssk, hot, absent, flt, sup, rop, rstb, lopen;
  logic rop_n, rstb_n, rfo, sse, opi, ampi, flti, sgi, mute, rso, rsoe, rfo2, rfoe, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int err_total, tests_run, cyc;
  tmc_far_model far (.aclk(aclk), .op_req(rop), .stb_req(rstb), .loop_open(lopen),
    .remote_operate_n(rop_n), .remote_standby_n(rstb_n), .rf_permit_open(rfo));
  tmc_top dut (.aclk(aclk), .aresetn(aresetn), .remote_operate_n(rop_n),
    .remote_standby_n(rstb_n), .panel_operate_key(pok), .panel_standby_key(psk),
    .serial_operate_cmd(sok), .serial_standby_cmd(ssk), .amp_overtemp(hot),
    .amp_absent(absent), .fault_detect(flt), .rf_output_path_permit_in(rfo), .supply_ok(sup),
    .supply_stage_en(sse), .operate_indicator(opi), .amp_enable_indicator(ampi),
    .fault_indicator(flti), .supply_good_indicator(sgi), .mute(mute),
    .remote_state_out(rso), .remote_state_oe_n(rsoe), .remote_fault_free_out(rfo2),
    .remote_fault_free_oe_n(rfoe), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // hang guard, run needs about 4000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic mode(input bit op);
    chk({sse, opi, ampi, rsoe}, op ? 4'b1110 : 4'b0001, "mode outputs");
  endtask : mode
  // write: both channels offered together, bready held until answer
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    chk(0, 1, "write timeout");
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    chk(0, 1, "read timeout");
  endtask : axr
  // one request from source s: remote, panel, serial, register
  task automatic req(input int s, input bit op);
    logic [1:0] rs;
    case (s)
      0: begin
        if (op) rop <= 1'b1; else rstb <= 1'b1;
        repeat (420) @(posedge aclk);
        rop <= 1'b0; rstb <= 1'b0;
        repeat (420) @(posedge aclk); // release must pass the filter too
      end
      1: begin
        if (op) pok <= 1'b1; else psk <= 1'b1;
        @(posedge aclk);
        pok <= 1'b0; psk <= 1'b0;
      end
      2: begin
        if (op) sok <= 1'b1; else ssk <= 1'b1;
        @(posedge aclk);
        sok <= 1'b0; ssk <= 1'b0;
      end
      default: axw(TMC_CTRL_OFS, op ? 32'h1 : 32'h2, rs);
    endcase
    repeat (4) @(posedge aclk);
  endtask : req
  initial begin
    {pok, psk, sok, ssk, hot, absent, flt, rop, rstb, lopen} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    sup = 1'b1; aresetn = 1'b0; err_total = 0; tests_run = 0; cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({sse, rsoe, rfoe, mute}, 4'b0111, "reset state");
    repeat (420) @(posedge aclk);
    for (int s = 0; s < 4; s++) begin
      req(s, 1'b1);
      mode(1'b1);
      req(s, 1'b0);
      mode(1'b0);
      chk(sgi, 1'b1, "supply lamp");
    end
    pok <= 1'b1;
    req(1, 1'b0);
    mode(1'b0);
    for (int i = 0; i < 2; i++) begin
      hot <= (i == 0); absent <= (i == 1);
      req(1, 1'b1);
      mode(1'b0);
    end
    hot <= 1'b0; absent <= 1'b0;
    // blocked entries above latched a fault; clear it before going on
    axw(TMC_CTRL_OFS, 32'h4, r);
    chk(r, AXI_RESP_OKAY, "clear write");
    rstb <= 1'b1;
    repeat (420) @(posedge aclk);
    req(1, 1'b1);
    mode(1'b0);
    rstb <= 1'b0;
    repeat (420) @(posedge aclk);
    // events cleared first so only the new entry shows
    axr(TMC_IRQ_OFS, d, r);
    axw(TMC_MASK_OFS, 32'h1 << EV_OPERATE, r);
    chk(irq, 1'b0, "irq idle");
    req(3, 1'b1);
    chk(irq, 1'b1, "irq raised");
    axr(TMC_IRQ_OFS, d, r);
    chk(d[EV_W-1:0], 5'h01, "events");
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0, "irq cleared");
    lopen <= 1'b1;
    repeat (420) @(posedge aclk);
    chk(mute, 1'b1, "loop open mute");
    mode(1'b1);
    lopen <= 1'b0;
    repeat (420) @(posedge aclk);
    chk(mute, 1'b0, "loop closed");
    flt <= 1'b1;
    repeat (4) @(posedge aclk);
    mode(1'b0);
    chk({flti, rfoe}, 2'b11, "fault lamp");
    flt <= 1'b0;
    req(1, 1'b1);
    mode(1'b0);
    axw(TMC_CTRL_OFS, 32'h4, r);
    repeat (4) @(posedge aclk);
    chk(rfoe, 1'b0, "fault-free driven");
    axr(TMC_IRQ_OFS, d, r);
    chk(d, 32'h0000_001e, "mute, fault, standby, refused events");
    req(2, 1'b1);
    mode(1'b1);
    axr(TMC_STATUS_OFS, d, r);
    chk(d, 32'h0000_0001, "status in operate");
    chk({rso, rfo2}, 2'b00, "open-collector levels");
    axr(8'h10, d, r);
    chk(r, AXI_RESP_SLVERR, "unmapped read");
    axw(TMC_STATUS_OFS, 32'h0, r);
    chk(r, AXI_RESP_SLVERR, "status write");
    axr(TMC_MASK_OFS, d, r);
    chk(d, 32'h1, "mask readback");
    end_of_test;
  end
endmodule : tb_top
